// >>> logic/drive_terminal_pkg.sv
// Constants, register map and carrier types for the drive terminal signal logic.
// Assumes a single 25 MHz control clock and an APB master on the register side.
package drive_terminal_pkg;

  // Register byte offsets on APB.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ASSIGN    = 8'h04;
  localparam logic [7:0] OFS_OUT_SEL   = 8'h08;
  localparam logic [7:0] OFS_START_F   = 8'h0c;
  localparam logic [7:0] OFS_STOP_F    = 8'h10;
  localparam logic [7:0] OFS_ARRIVAL   = 8'h14;
  localparam logic [7:0] OFS_DETECT    = 8'h18;
  localparam logic [7:0] OFS_UV_LEVEL  = 8'h1c;
  localparam logic [7:0] OFS_STATUS    = 8'h20;
  localparam logic [7:0] OFS_EXT_STAT  = 8'h24;

  // Control register field positions.
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_F1_ANALOG  = 2;
  localparam int CTRL_BYPASS     = 3;

  // Input function codes.
  localparam logic [7:0] IN_SERIAL   = 8'h18;
  localparam logic [7:0] IN_CLEAR    = 8'h21;
  localparam logic [7:0] IN_FREEZE   = 8'h22;
  localparam logic [7:0] IN_FORWARD  = 8'h62;
  localparam logic [7:0] IN_BACKWARD = 8'h63;

  // Output signal codes and polarity offset.
  localparam logic [10:0] OUT_NEG_OFFSET = 11'h3e8;
  localparam logic [10:0] SIG_ALARM      = 11'h063;

  // Reset values; selectors default to running and alarm, active high.
  localparam logic [10:0] RST_TR_SEL    = 11'h000;
  localparam logic [10:0] RST_RELAY_SEL = 11'h063;
  localparam logic [7:0]  RST_ASSIGN_A  = 8'h62;
  localparam logic [7:0]  RST_ASSIGN_B  = 8'h63;
  localparam logic [3:0]  RST_MODE      = 4'h1;

  // Power-on settling time outside logic should mask, in ms.
  localparam int SETTLE_MS = 1500;

  typedef enum logic [1:0] {
    LOOP_OFF    = 2'h0,
    LOOP_NORMAL = 2'h1,
    LOOP_INVERS = 2'h2
  } loop_mode_e;

  // Status carrier from the motor core.
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] ref_freq;
    logic [15:0] bus_volt;
    logic        dc_braking;
    logic        uv_tripped;
    logic        any_trip;
  } core_stat_s;

  // Command carrier toward the motor core.
  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic use_serial;
    logic loop_enable;
    logic loop_inverse;
    logic f1_invert;
    logic integ_clear;
    logic deriv_clear;
    logic integ_hold;
  } core_cmd_s;

endpackage : drive_terminal_pkg

// >>> logic/drive_terminal_signal_logic.sv
// Terminal command decode and programmable status outputs of a motor drive.
// Assumes terminal pins are asynchronous and the core status is on clk.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module drive_terminal_signal_logic
  import drive_terminal_pkg::*;
#(
  parameter int N_IN = 5
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_IN-1:0]   term_in,
  input  wire logic [31:0]       ext_status,
  input  wire core_stat_s        core_stat,
  output core_cmd_s              core_cmd,
  output logic                   transistor_out,
  output logic                   relay_coil
);

  // Refuse terminal counts outside 2 to 8; the 32-bit function-code write only sets codes for terminals 0 to 3.
  if (N_IN < 2 || N_IN > 8) begin : g_n_in_check
    $error("N_IN must be from 2 to 8");
  end

  typedef struct packed {
    logic [N_IN-1:0] sync1;
    logic [N_IN-1:0] sync2;
    logic [3:0]      ctrl;
    logic [N_IN*8-1:0] in_func;
    logic [7:0]      input_assign_a;
    logic [7:0]      input_assign_b;
    logic [10:0]     transistor_out_select;
    logic [10:0]     relay_out_select;
    logic [15:0]     start_freq;
    logic [15:0]     stop_freq;
    logic [15:0]     arrival_band_width;
    logic [15:0]     detect_level;
    logic [15:0]     detect_hysteresis;
    logic [15:0]     uv_level;
    logic            motor_active;
    logic            speed_reached_flag;
    logic            speed_threshold_flag;
    logic            bus_voltage_low_flag;
    logic            any_fault_out;
    core_cmd_s       cmd;
    logic            tr_pin;
    logic            relay_pin;
    logic [31:0]     rdata;
  } state_s;

  state_s st;
  state_s next_st;

  // Terminal-driven command levels after function decode.
  logic [N_IN-1:0] hit_serial;
  logic [N_IN-1:0] hit_clear;
  logic [N_IN-1:0] hit_freeze;
  logic [N_IN-1:0] hit_fwd;
  logic [N_IN-1:0] hit_rev;
  logic [N_IN-1:0] serial_assigned;

  // Each terminal reads only the second sync stage against its function code.
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_term
      wire [7:0] fcode = st.in_func[gi*8 +: 8];
      wire       lvl   = st.sync2[gi];
      assign serial_assigned[gi] = (fcode == IN_SERIAL);
      assign hit_serial[gi] = lvl && (fcode == IN_SERIAL);
      assign hit_clear[gi]  = lvl && (fcode == IN_CLEAR);
      assign hit_freeze[gi] = lvl && (fcode == IN_FREEZE);
      // Run functions count only on the terminals named by the two assigns.
      assign hit_fwd[gi] = lvl && (fcode == IN_FORWARD) &&
                           ((8'(gi) == st.input_assign_a) || (8'(gi) == st.input_assign_b));
      assign hit_rev[gi] = lvl && (fcode == IN_BACKWARD) &&
                           ((8'(gi) == st.input_assign_a) || (8'(gi) == st.input_assign_b));
    end
  endgenerate

  // Selects a status signal by code and applies the polarity offset.
  function automatic logic sel_out(input logic [10:0] code, input logic [31:0] sig_vec,
                                   input logic run, input logic reached, input logic above,
                                   input logic low_bus, input logic fault, input logic run2);
    logic [10:0] base;
    logic        neg;
    logic        v;
    neg  = (code >= OUT_NEG_OFFSET);
    base = neg ? 11'(code - OUT_NEG_OFFSET) : code;
    unique case (base)
      11'h000: v = run;
      11'h001: v = reached;
      11'h002: v = above;
      11'h003: v = low_bus;
      11'h023: v = run2;
      11'h057: v = reached && above;
      11'h063: v = fault;
      11'h005, 11'h006, 11'h007, 11'h01a, 11'h01e, 11'h024, 11'h025, 11'h026,
      11'h027, 11'h028, 11'h029, 11'h02a, 11'h02b, 11'h02c, 11'h031, 11'h038,
      11'h039, 11'h03b, 11'h054: v = sig_vec[base[4:0]];
      default: v = 1'b0;
    endcase
    return v ^ neg;
  endfunction : sel_out

  logic [16:0] diff;
  logic [15:0] drop_level;
  logic        run2;
  logic        serial_on;
  logic        run_block;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;

  always_comb begin
    diff = (core_stat.out_freq >= core_stat.ref_freq)
           ? {1'b0, core_stat.out_freq - core_stat.ref_freq}
           : {1'b0, core_stat.ref_freq - core_stat.out_freq};
    drop_level = (st.detect_level > st.detect_hysteresis)
              ? 16'(st.detect_level - st.detect_hysteresis) : 16'h0000;
    run2 = core_stat.out_freq > st.start_freq;
    // No assigned terminal means the serial link always has priority.
    serial_on = (|serial_assigned) ? (|hit_serial) : 1'b1;
    run_block = st.bus_voltage_low_flag;
    wr_en = psel && penable && pwrite;
    rd_en = psel && !pwrite;
    addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFS_EXT_STAT);
  end

  // Next-state: synchronisers, registers, status flags, commands and pins.
  always_comb begin
    next_st = st;
    next_st.sync1 = term_in;
    next_st.sync2 = st.sync1;

    if (wr_en) begin
      unique case (paddr)
        OFS_CTRL:    next_st.ctrl = pwdata[3:0];
        OFS_ASSIGN: begin
          next_st.input_assign_a = pwdata[7:0];
          next_st.input_assign_b = pwdata[15:8];
        end
        OFS_OUT_SEL: begin
          next_st.transistor_out_select = pwdata[10:0];
          next_st.relay_out_select      = pwdata[26:16];
        end
        OFS_START_F: next_st.start_freq = pwdata[15:0];
        OFS_STOP_F:  next_st.stop_freq  = pwdata[15:0];
        OFS_ARRIVAL: next_st.arrival_band_width = pwdata[15:0];
        OFS_DETECT: begin
          next_st.detect_level      = pwdata[15:0];
          next_st.detect_hysteresis = pwdata[31:16];
        end
        OFS_UV_LEVEL: next_st.uv_level = pwdata[15:0];
        OFS_STATUS:   next_st.in_func = (N_IN*8)'(pwdata);
        default: ;
      endcase
    end

    // Running flag with start/stop hysteresis, forced off while braking.
    if (core_stat.dc_braking) begin
      next_st.motor_active = 1'b0;
    end else if (core_stat.out_freq > st.start_freq) begin
      next_st.motor_active = 1'b1;
    end else if (core_stat.out_freq < st.stop_freq) begin
      next_st.motor_active = 1'b0;
    end

    next_st.speed_reached_flag = (diff <= {1'b0, st.arrival_band_width});

    if (core_stat.out_freq > st.detect_level) begin
      next_st.speed_threshold_flag = 1'b1;
    end else if (core_stat.out_freq < drop_level) begin
      next_st.speed_threshold_flag = 1'b0;
    end

    // Low bus flag follows the level, and holds while the trip persists.
    if (core_stat.uv_tripped) begin
      next_st.bus_voltage_low_flag = 1'b1;
    end else if (core_stat.bus_volt < st.uv_level) begin
      next_st.bus_voltage_low_flag = 1'b1;
    end else begin
      next_st.bus_voltage_low_flag = 1'b0;
    end

    next_st.any_fault_out = core_stat.any_trip;

    // Commands toward the motor core.
    next_st.cmd.run_fwd    = (|hit_fwd) && !run_block;
    next_st.cmd.run_rev    = (|hit_rev) && !run_block;
    next_st.cmd.use_serial = serial_on;
    next_st.cmd.loop_enable = (st.ctrl[1:0] != LOOP_OFF) && !st.ctrl[CTRL_BYPASS];
    next_st.cmd.loop_inverse = (st.ctrl[1:0] == LOOP_NORMAL) ? st.ctrl[CTRL_F1_ANALOG]
                             : !st.ctrl[CTRL_F1_ANALOG];
    next_st.cmd.f1_invert  = st.ctrl[CTRL_F1_ANALOG] && (st.ctrl[1:0] == LOOP_OFF);
    next_st.cmd.integ_clear = |hit_clear;
    next_st.cmd.deriv_clear = |hit_clear;
    next_st.cmd.integ_hold  = |hit_freeze;

    // Registered pins; relay coil energises on an active selected signal.
    next_st.tr_pin = sel_out(st.transistor_out_select, ext_status, st.motor_active,
                             st.speed_reached_flag, st.speed_threshold_flag,
                             st.bus_voltage_low_flag, st.any_fault_out, run2);
    next_st.relay_pin = sel_out(st.relay_out_select, ext_status, st.motor_active,
                                st.speed_reached_flag, st.speed_threshold_flag,
                                st.bus_voltage_low_flag, st.any_fault_out, run2);

    next_st.rdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        OFS_CTRL:     next_st.rdata = {28'h0, st.ctrl};
        OFS_ASSIGN:   next_st.rdata = {16'h0, st.input_assign_b, st.input_assign_a};
        OFS_OUT_SEL:  next_st.rdata = {5'h0, st.relay_out_select, 5'h0,
                                       st.transistor_out_select};
        OFS_START_F:  next_st.rdata = {16'h0, st.start_freq};
        OFS_STOP_F:   next_st.rdata = {16'h0, st.stop_freq};
        OFS_ARRIVAL:  next_st.rdata = {16'h0, st.arrival_band_width};
        OFS_DETECT:   next_st.rdata = {st.detect_hysteresis, st.detect_level};
        OFS_UV_LEVEL: next_st.rdata = {16'h0, st.uv_level};
        OFS_STATUS:   next_st.rdata = 32'({st.relay_pin, st.tr_pin, st.any_fault_out,
                                           st.bus_voltage_low_flag, st.speed_threshold_flag,
                                           st.speed_reached_flag, st.motor_active});
        OFS_EXT_STAT: next_st.rdata = 32'(st.in_func);
        default: ;
      endcase
    end
  end

  // State register; selectors reset to active-high codes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.ctrl <= RST_MODE;
      st.input_assign_a <= RST_ASSIGN_A;
      st.input_assign_b <= RST_ASSIGN_B;
      st.transistor_out_select <= RST_TR_SEL;
      st.relay_out_select <= RST_RELAY_SEL;
    end else begin
      st <= next_st;
    end
  end

  // APB answer: one wait-free access; unmapped or misaligned gives an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = st.rdata;
  assign core_cmd = st.cmd;
  assign transistor_out = st.tr_pin;
  assign relay_coil = st.relay_pin;

  // Threshold flag holds between the two levels.
  hold_band_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st.speed_threshold_flag && core_stat.out_freq >= drop_level &&
     core_stat.out_freq <= st.detect_level) |=> st.speed_threshold_flag)
    else $error("threshold flag dropped inside hysteresis band");

  brake_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    core_stat.dc_braking |=> !st.motor_active)
    else $error("running flag set during braking");

  uv_trip_a: assert property (@(posedge clk) disable iff (!arst_n)
    core_stat.uv_tripped |=> st.bus_voltage_low_flag)
    else $error("low bus flag clear during trip");

  run_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.bus_voltage_low_flag |=> !st.cmd.run_fwd && !st.cmd.run_rev)
    else $error("run accepted during low bus voltage");

  fault_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    core_stat.any_trip |=> st.any_fault_out)
    else $error("fault output missed a trip");

  sequence clear_seen;
    |hit_clear;
  endsequence
  loop_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    clear_seen |=> (st.cmd.integ_clear && st.cmd.deriv_clear))
    else $error("loop clear not applied to both terms");

  serial_default_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(|serial_assigned) |=> st.cmd.use_serial)
    else $error("serial priority not default active");

  arrival_band_a: assert property (@(posedge clk) disable iff (!arst_n)
    (diff > {1'b0, st.arrival_band_width}) |=> !st.speed_reached_flag)
    else $error("speed reached outside band");

  // Run requests on an assigned terminal while the bus is healthy.
  sequence fwd_request;
    (|hit_fwd) && !st.bus_voltage_low_flag;
  endsequence
  sequence rev_request;
    (|hit_rev) && !st.bus_voltage_low_flag;
  endsequence

  // Forward request reaches the core one edge later.
  fwd_run_a: assert property (@(posedge clk) disable iff (!arst_n)
    fwd_request |=> st.cmd.run_fwd)
    else $error("forward request not passed to the core");

  // Backward request reaches the core one edge later.
  rev_run_a: assert property (@(posedge clk) disable iff (!arst_n)
    rev_request |=> st.cmd.run_rev)
    else $error("backward request not passed to the core");

  // Integral freeze follows its terminal.
  freeze_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|hit_freeze) |=> st.cmd.integ_hold)
    else $error("integral freeze not applied");

  // With a terminal assigned, serial priority follows that terminal.
  serial_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|serial_assigned) |=> (st.cmd.use_serial == (|$past(hit_serial))))
    else $error("serial priority does not follow its terminal");

  // Loop direction is inverse for mode 2, flipped by the invert command.
  loop_dir_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st.ctrl[1:0] == LOOP_NORMAL || st.ctrl[1:0] == LOOP_INVERS) |=>
    (st.cmd.loop_inverse == ($past(st.ctrl[1]) ^ $past(st.ctrl[CTRL_F1_ANALOG]))))
    else $error("loop direction wrong for mode and invert command");

  // Bypass hands control to the manual setting.
  bypass_manual_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.ctrl[CTRL_BYPASS] |=> !st.cmd.loop_enable)
    else $error("loop left enabled under bypass");

  // With a loop mode set, invert never reaches the manual reference.
  manual_dir_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st.ctrl[1:0] != LOOP_OFF) |=> !st.cmd.f1_invert)
    else $error("invert applied to manual reference under loop mode");

  // Transistor pin on code 0 mirrors the running flag.
  run_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st.transistor_out_select == 11'h000) |=> (st.tr_pin == $past(st.motor_active)))
    else $error("transistor pin does not follow running flag");

  // Relay on code 1000 shows the running flag inverted.
  neg_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st.relay_out_select == OUT_NEG_OFFSET) |=> (st.relay_pin != $past(st.motor_active)))
    else $error("inverted code did not invert the pin");

  // Relay on the alarm code energises while the fault output is set.
  alarm_relay_a: assert property (@(posedge clk) disable iff (!arst_n)
    (st.relay_out_select == SIG_ALARM) |=> (st.relay_pin == $past(st.any_fault_out)))
    else $error("relay does not follow the fault output");

  // Bus below the undervoltage level sets the low bus flag.
  low_bus_a: assert property (@(posedge clk) disable iff (!arst_n)
    (core_stat.bus_volt < st.uv_level) |=> st.bus_voltage_low_flag)
    else $error("low bus flag missed a low bus voltage");

  // Output above the detect level sets the threshold flag.
  threshold_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    (core_stat.out_freq > st.detect_level) |=> st.speed_threshold_flag)
    else $error("threshold flag not set above detect level");

  // Output above the start frequency sets the running flag unless braking.
  running_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!core_stat.dc_braking && core_stat.out_freq > st.start_freq) |=> st.motor_active)
    else $error("running flag not set above start frequency");

endmodule : drive_terminal_signal_logic

// >>> tb/term_partner.sv
// Partner model: field wiring and controller on the drive terminals.
// Assumes the bench names the wanted levels; they reach the pins on clk edges.
`timescale 1ns/100ps
module term_partner
  import drive_terminal_pkg::*;
#(
  parameter int N_IN       = 5,
  parameter int SETTLE_CYC = 24
) (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic [N_IN-1:0] want_term,
  input  wire core_stat_s      want_stat,
  input  wire logic            transistor_out,
  input  wire logic            relay_coil,
  output logic      [N_IN-1:0] term_in,
  output core_stat_s           core_stat,
  output logic                 pins_valid,
  output logic      [1:0]      pins_seen
);
  logic [15:0] settle_cnt;

  // Switch levels and core status move just after a rising edge.
  initial begin
    term_in   = '0;
    core_stat = want_stat;
  end
  always @(posedge clk) begin
    term_in   <= want_term;
    core_stat <= want_stat;
  end

  // Status pins are not trusted until the settling count after reset expires.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) settle_cnt <= '0;
    else if (settle_cnt != SETTLE_CYC[15:0]) settle_cnt <= settle_cnt + 16'h0001;
  end
  assign pins_valid = (settle_cnt == SETTLE_CYC[15:0]);
  assign pins_seen  = pins_valid ? {relay_coil, transistor_out} : 2'b00;
endmodule : term_partner

// >>> tb/tb_top.sv
// Self-checking bench for the drive terminal signal logic.
// Assumes the design answers APB at once and the partner drives terminals.
`timescale 1ns/100ps
module tb_top
  import drive_terminal_pkg::*;
;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic        err;
    logic [8:0]  cmd;
    logic [8:0]  cm;
    logic [1:0]  pins;
    logic        pm;
  } note_s;
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, ext_status = '0;
  logic        pready, pslverr, transistor_out, relay_coil, pins_valid;
  logic [4:0]  term_in, want_term = '0;
  logic [1:0]  pins_seen;
  core_stat_s  core_stat, want_stat = '{16'd0, 16'd0, 16'd600, 1'b0, 1'b0, 1'b1};
  core_cmd_s   core_cmd;
  note_s       notes[$];
  note_s       mon_n;
  int          miscompares = 0, checked = 0, cyc = 0;
  logic [10:0] codes [23] = '{0, 1, 2, 3, 5, 6, 7, 26, 30, 35, 36, 37, 38, 41, 43, 44, 49,
                              56, 57, 59, 84, 87, 99};

  drive_terminal_signal_logic #(.N_IN(5)) i_dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .term_in(term_in), .ext_status(ext_status),
    .core_stat(core_stat), .core_cmd(core_cmd), .transistor_out(transistor_out),
    .relay_coil(relay_coil));
  term_partner #(.N_IN(5), .SETTLE_CYC(24)) i_partner (.clk(clk), .arst_n(arst_n),
    .want_term(want_term), .want_stat(want_stat), .transistor_out(transistor_out),
    .relay_coil(relay_coil), .term_in(term_in), .core_stat(core_stat),
    .pins_valid(pins_valid), .pins_seen(pins_seen));

  // Clock at 25 MHz.
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic end_sim;
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     input note_s n);
    notes.push_back(n);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m, input logic err);
    apb(w, a, d, '{e, m, err, 9'h0, 9'h0, 2'h0, 1'b0});
  endtask : xfer

  task automatic cmd_chk(input core_cmd_s e, input core_cmd_s m);
    apb(1'b0, OFS_CTRL, 32'h0, '{32'h0, 32'h0, 1'b0, e, m, 2'h0, 1'b0});
  endtask : cmd_chk

  task automatic stat_chk(input logic [6:0] f, input logic [6:0] fm);
    apb(1'b0, OFS_STATUS, 32'h0, '{{25'h0, f}, {25'h0, fm}, 1'b0, 9'h0, 9'h0, f[6:5], 1'b1});
  endtask : stat_chk

  // Flags are {fault, low bus, threshold, reached, running}; default selectors on pins.
  task automatic st(input logic [15:0] o, r, b, input logic [2:0] ctl, input logic [4:0] f);
    want_stat <= '{o, r, b, ctl[2], ctl[1], ctl[0]};
    settle(5);
    stat_chk({f[4], f[0], f}, 7'h7f);
  endtask : st

  task automatic term_case(input logic [4:0] t, input logic forward_go_cmd, input logic ser);
    core_cmd_s e, m;
    want_term <= t;
    settle(5);
    e = '0;
    m = '0;
    {e.run_fwd, e.use_serial} = {forward_go_cmd, ser};
    {m.run_fwd, m.use_serial} = 2'b11;
    cmd_chk(e, m);
  endtask : term_case

  // Signal each output code should show in the final status state.
  function automatic logic exp_sig(input logic [10:0] c);
    case (c)
      11'd0, 11'd3: return 1'b0;
      11'd1, 11'd2, 11'd35, 11'd87, 11'd99: return 1'b1;
      default: return ext_status[c[4:0]];
    endcase
  endfunction : exp_sig

  // Scoreboard: each completed transfer is judged against the oldest note.
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      if (notes.size() == 0) check(32'h1, 32'h0);
      else begin
        mon_n = notes.pop_front();
        check(prdata & mon_n.m, mon_n.d & mon_n.m);
        check({31'h0, pslverr}, {31'h0, mon_n.err});
        check({23'h0, core_cmd} & {23'h0, mon_n.cm}, {23'h0, mon_n.cmd & mon_n.cm});
        if (mon_n.pm && pins_valid) check({30'h0, pins_seen}, {30'h0, mon_n.pins});
      end
    end
  end

  // Hang guard.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      end_sim();
    end
  end

  // Main sequence.
  initial begin
    core_cmd_s   e, lm;
    logic [10:0] c;
    logic        s;
    void'($urandom(11));
    settle(8);
    arst_n <= 1'b1;
    xfer(1'b0, OFS_CTRL, 32'h0, 32'h1, 32'hf, 1'b0);
    xfer(1'b0, OFS_ASSIGN, 32'h0, 32'h6362, 32'hffff, 1'b0);
    xfer(1'b0, OFS_OUT_SEL, 32'h0, 32'h0063_0000, 32'h07ff_07ff, 1'b0);
    xfer(1'b0, 8'h28, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
    xfer(1'b0, 8'h02, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
    xfer(1'b1, 8'h2c, 32'hffff_ffff, 32'h0, 32'h0, 1'b1);
    settle(30);
    stat_chk(7'h52, 7'h73);
    xfer(1'b1, OFS_START_F, 32'd100, 0, 0, 1'b0);
    xfer(1'b1, OFS_STOP_F, 32'd50, 0, 0, 1'b0);
    xfer(1'b1, OFS_ARRIVAL, 32'd20, 0, 0, 1'b0);
    xfer(1'b1, OFS_DETECT, {16'd100, 16'd1000}, 0, 0, 1'b0);
    xfer(1'b1, OFS_UV_LEVEL, 32'd300, 0, 0, 1'b0);
    st(16'd150, 16'd500, 16'd600, 3'b000, 5'b00001);
    st(16'd75, 16'd500, 16'd600, 3'b000, 5'b00001);
    st(16'd40, 16'd500, 16'd600, 3'b000, 5'b00000);
    st(16'd150, 16'd500, 16'd600, 3'b100, 5'b00000);
    st(16'd150, 16'd160, 16'd600, 3'b000, 5'b00011);
    st(16'd150, 16'd140, 16'd600, 3'b000, 5'b00011);
    st(16'd150, 16'd200, 16'd600, 3'b000, 5'b00001);
    st(16'd1001, 16'd2000, 16'd600, 3'b000, 5'b00101);
    st(16'd950, 16'd2000, 16'd600, 3'b000, 5'b00101);
    st(16'd899, 16'd2000, 16'd600, 3'b000, 5'b00001);
    st(16'd950, 16'd2000, 16'd250, 3'b000, 5'b01001);
    st(16'd950, 16'd2000, 16'd600, 3'b010, 5'b01001);
    st(16'd950, 16'd2000, 16'd600, 3'b001, 5'b10001);
    lm = '0;
    {lm.loop_enable, lm.loop_inverse, lm.f1_invert} = 3'b111;
    for (int md = 1; md <= 2; md++) begin
      for (int iv = 0; iv <= 1; iv++) begin
        xfer(1'b1, OFS_CTRL, {29'h0, iv[0], md[1:0]}, 0, 0, 1'b0);
        settle(4);
        e = '0;
        {e.loop_enable, e.loop_inverse} = {1'b1, md[1] ^ iv[0]};
        cmd_chk(e, lm);
      end
    end
    xfer(1'b1, OFS_CTRL, 32'hd, 0, 0, 1'b0);
    settle(4);
    e = '0;
    e.loop_inverse = 1'b1;
    cmd_chk(e, lm);
    for (int iv = 0; iv <= 1; iv++) begin
      xfer(1'b1, OFS_CTRL, {29'h0, iv[0], 2'b00}, 0, 0, 1'b0);
      settle(4);
      e = '0;
      {e.f1_invert, e.loop_inverse} = {iv[0], ~iv[0]};
      cmd_chk(e, lm);
    end
    xfer(1'b1, OFS_ASSIGN, 32'h0000_0100, 0, 0, 1'b0);
    xfer(1'b1, OFS_STATUS, 32'h2221_6362, 0, 0, 1'b0);
    lm = '0;
    {lm.run_fwd, lm.run_rev, lm.use_serial, lm.integ_clear, lm.deriv_clear} = 5'h1f;
    lm.integ_hold = 1'b1;
    for (int t = 0; t < 5; t++) begin
      want_term <= (t < 4) ? 5'(1 << t) : 5'h0;
      settle(5);
      e = '0;
      {e.run_fwd, e.run_rev, e.use_serial} = {t == 0, t == 1, 1'b1};
      {e.integ_clear, e.deriv_clear, e.integ_hold} = {t == 2, t == 2, t == 3};
      cmd_chk(e, lm);
    end
    xfer(1'b1, OFS_STATUS, 32'h1862_6362, 0, 0, 1'b0);
    term_case(5'b00100, 1'b0, 1'b0);
    term_case(5'b01000, 1'b0, 1'b1);
    term_case(5'b00001, 1'b1, 1'b0);
    st(16'd950, 16'd2000, 16'd250, 3'b000, 5'b01001);
    term_case(5'b00001, 1'b0, 1'b0);
    st(16'd1001, 16'd1010, 16'd600, 3'b101, 5'b10110);
    ext_status <= $urandom;
    for (int k = 0; k < 23; k++) begin
      c = codes[k];
      s = exp_sig(c);
      xfer(1'b1, OFS_OUT_SEL, {5'h0, c + OUT_NEG_OFFSET, 5'h0, c}, 0, 0, 1'b0);
      settle(4);
      stat_chk({~s, s, 5'h00}, 7'h60);
    end
    settle(3);
    end_sim();
  end
endmodule : tb_top
